// ### src/pmrs_consts.svh
// constants of the reset/sleep state controller: offsets, fields, reset values, times
// assumes a 100 MHz core clock; times are kept in their own units and turned into cycles
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH

`define PMRS_CLK_PERIOD_NS 10
`define PMRS_US_NS 1000
`define PMRS_US_PER_MS 1000
`define PMRS_SW_HALF_NS 227
`define PMRS_SOFTSTART_MS 1
`define PMRS_MAX_DELAY_MS 75
`define PMRS_OCP_HITS 32
`define PMRS_HICCUP_MS 8
`define PMRS_SAFE_TIMEOUT_MS 16

`define PMRS_OFF_CTRL 8'h00
`define PMRS_OFF_HOLD 8'h04
`define PMRS_OFF_SLEEP 8'h08
`define PMRS_OFF_ROUTE 8'h0C
`define PMRS_OFF_DELAY 8'h10
`define PMRS_OFF_WINDOW 8'h14
`define PMRS_OFF_VSET 8'h18
`define PMRS_OFF_STATUS 8'h1C

`define PMRS_CTRL_LPA 0
`define PMRS_CTRL_DIS_LSB 1
`define PMRS_CTRL_OVSEL_LSB 8
`define PMRS_CTRL_UVSEL_LSB 10
`define PMRS_SLEEP_BLANK_LSB 8
`define PMRS_SLEEP_DEGL_LSB 16
`define PMRS_ROUTE_WD 5

`define PMRS_MASK_CTRL 32'h0000_0F3F
`define PMRS_MASK_HOLD 32'h0000_00FF
`define PMRS_MASK_SLEEP 32'h00FF_FF0F
`define PMRS_MASK_ROUTE 32'h0000_003F
`define PMRS_MASK_WINDOW 32'h0000_FFFF
`define PMRS_MASK_VSET 32'h0000_1F1F

`define PMRS_RST_CTRL 32'h0000_0000
`define PMRS_RST_HOLD 32'h0000_000A
`define PMRS_RST_SLEEP 32'h0014_1400
`define PMRS_RST_ROUTE 32'h0000_003F
`define PMRS_RST_DELAY 32'h0000_0000
`define PMRS_RST_WINDOW 32'h0000_0000
`define PMRS_RST_VSET 32'h0000_0808

`endif

// ### src/pmrs_pkg.sv
// types of the reset/sleep state controller
// used by the controller top only
package pmrs_pkg;
   typedef enum logic [3:0] {
      ST_OFF,
      ST_POWERUP,
      ST_NORMAL,
      ST_RESET,
      ST_SLEEP,
      ST_RECOVER,
      ST_RECOVERY_RESET,
      ST_SAFE_SHUTDOWN,
      ST_HICCUP
   } pmrs_state_type;
endpackage

// ### src/pmrs_top.sv
// reset, sleep and protection state controller for a five-rail supply, with APB registers
// assumes analog flags and pins are asynchronous levels; the core clock runs at 100 MHz
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pmrs_consts.svh"

module pmrs_top
   import pmrs_pkg::*;
#(
   parameter int US_CYCLES = `PMRS_US_NS / `PMRS_CLK_PERIOD_NS,
   parameter int US_PER_MS = `PMRS_US_PER_MS
)
(
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [4:0] RAIL_WINDOW_FAULT,
   input wire logic [4:0] RAIL_SEVERE_OV,
   input wire logic [4:0] RAIL_SEVERE_UV,
   input wire logic [4:0] RAIL_PEAK_LIMIT,
   input wire logic [4:0] RAIL_CYCLE_TICK,
   input wire logic WATCHDOG_FAIL,
   input wire logic OVER_TEMP,
   input wire logic VIN_ABOVE_RISE,
   input wire logic VIN_BELOW_FALL,
   input wire logic EN_ABOVE_ON,
   input wire logic EN_BELOW_OFF,
   input wire logic REG_SUPPLY_OV,
   input wire logic SLEEP_REQUEST_N,
   output logic SYSTEM_RESET_OUT_O,
   output logic SYSTEM_RESET_OUT_OE_N,
   output logic [4:0] RAIL_ENABLE,
   output logic [4:0] RAIL_DISCHARGE,
   output logic [4:0] RAIL_SWITCH_STOP,
   output logic WATCHDOG_RESTART,
   output logic [4:0] CORE_RAIL_A_VSET,
   output logic [4:0] CORE_RAIL_B_VSET,
   output logic CORE_RAIL_A_PHASE,
   output logic CORE_RAIL_B_PHASE,
   output logic [1:0] SEVERE_OVER_LIMIT_SEL,
   output logic [1:0] SEVERE_UNDER_LIMIT_SEL,
   output logic [7:0] RAIL_WINDOW_CFG_A,
   output logic [7:0] RAIL_WINDOW_CFG_B
);

   localparam int NSYNC = 33;
   localparam int SW_HALF = `PMRS_SW_HALF_NS / `PMRS_CLK_PERIOD_NS;

   // synchronisers; only the second stage is ever read
   logic [NSYNC-1:0] sync1_r, sync2_r;
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= {SLEEP_REQUEST_N, REG_SUPPLY_OV, EN_BELOW_OFF, EN_ABOVE_ON,
                     VIN_BELOW_FALL, VIN_ABOVE_RISE, OVER_TEMP, WATCHDOG_FAIL,
                     RAIL_CYCLE_TICK, RAIL_PEAK_LIMIT, RAIL_SEVERE_UV, RAIL_SEVERE_OV,
                     RAIL_WINDOW_FAULT};
         sync2_r <= sync1_r;
      end
   end

   logic [4:0] win_s, sov_s, suv_s, peak_s, tick_s;
   logic wd_fail_s, ot_s, vin_hi_s, vin_lo_s, en_hi_s, en_lo_s, vreg_ov_s, sleep_n_s;
   assign win_s = sync2_r[4:0];
   assign sov_s = sync2_r[9:5];
   assign suv_s = sync2_r[14:10];
   assign peak_s = sync2_r[19:15];
   assign tick_s = sync2_r[24:20];
   assign {sleep_n_s, vreg_ov_s, en_lo_s, en_hi_s, vin_lo_s, vin_hi_s, ot_s, wd_fail_s} =
      sync2_r[32:25];

   // registers
   logic [31:0] ctrl_r, hold_r, sleep_r, route_r, delay_r, window_r, vset_r;
   logic [31:0] status;
   logic [31:0] rdata_nxt;
   logic hit, wr_en;
   pmrs_state_type state_r, state_nxt;

   assign wr_en = PSEL && PENABLE && PWRITE && PREADY;

   always_comb
   begin
      hit = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (PADDR == `PMRS_OFF_CTRL) rdata_nxt = ctrl_r;
      else if (PADDR == `PMRS_OFF_HOLD) rdata_nxt = hold_r;
      else if (PADDR == `PMRS_OFF_SLEEP) rdata_nxt = sleep_r;
      else if (PADDR == `PMRS_OFF_ROUTE) rdata_nxt = route_r;
      else if (PADDR == `PMRS_OFF_DELAY) rdata_nxt = delay_r;
      else if (PADDR == `PMRS_OFF_WINDOW) rdata_nxt = window_r;
      else if (PADDR == `PMRS_OFF_VSET) rdata_nxt = vset_r;
      else if (PADDR == `PMRS_OFF_STATUS) rdata_nxt = status;
      else hit = 1'b0;
   end

   // zero-wait slave: ready rises for the access phase that follows each setup
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end
      else
      begin
         PREADY <= PSEL && !PENABLE;
         if (PSEL && !PENABLE)
         begin
            PSLVERR <= !hit || (PWRITE && PADDR == `PMRS_OFF_STATUS);
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata_nxt;
         end
      end
   end

   function automatic logic [7:0] clamp_delay(input logic [7:0] v);
      clamp_delay = (v > 8'(`PMRS_MAX_DELAY_MS)) ? 8'(`PMRS_MAX_DELAY_MS) : {1'b0, v[6:0]};
   endfunction

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         hold_r <= `PMRS_RST_HOLD;
         sleep_r <= `PMRS_RST_SLEEP;
         route_r <= `PMRS_RST_ROUTE;
         delay_r <= `PMRS_RST_DELAY;
         window_r <= `PMRS_RST_WINDOW;
         vset_r <= `PMRS_RST_VSET;
      end
      else if (wr_en)
      begin
         if (PADDR == `PMRS_OFF_HOLD) hold_r <= PWDATA & `PMRS_MASK_HOLD;
         else if (PADDR == `PMRS_OFF_SLEEP) sleep_r <= PWDATA & `PMRS_MASK_SLEEP;
         else if (PADDR == `PMRS_OFF_ROUTE) route_r <= PWDATA & `PMRS_MASK_ROUTE;
         else if (PADDR == `PMRS_OFF_DELAY)
            delay_r <= {clamp_delay(PWDATA[31:24]), clamp_delay(PWDATA[23:16]),
                        clamp_delay(PWDATA[15:8]), clamp_delay(PWDATA[7:0])};
         else if (PADDR == `PMRS_OFF_WINDOW) window_r <= PWDATA & `PMRS_MASK_WINDOW;
         else if (PADDR == `PMRS_OFF_VSET) vset_r <= PWDATA & `PMRS_MASK_VSET;
      end
   end

   // sleep permission is spent on every wake, so software must grant it again
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         ctrl_r <= `PMRS_RST_CTRL;
      else if (wr_en && PADDR == `PMRS_OFF_CTRL)
         ctrl_r <= PWDATA & `PMRS_MASK_CTRL;
      else if (state_r == ST_SLEEP && state_nxt != ST_SLEEP)
         ctrl_r[`PMRS_CTRL_LPA] <= 1'b0;
   end

   logic low_power_allow;
   logic [4:0] bus_dis;
   logic [3:0] sleep_rail_select_cfg;
   logic [7:0] blank_us, degl_us, reset_hold_time_cfg;
   logic [5:0] fault_to_reset_routing;
   assign low_power_allow = ctrl_r[`PMRS_CTRL_LPA];
   assign bus_dis = ctrl_r[`PMRS_CTRL_DIS_LSB +: 5];
   assign sleep_rail_select_cfg = sleep_r[3:0];
   assign blank_us = sleep_r[`PMRS_SLEEP_BLANK_LSB +: 8];
   assign degl_us = sleep_r[`PMRS_SLEEP_DEGL_LSB +: 8];
   assign reset_hold_time_cfg = hold_r[7:0];
   assign fault_to_reset_routing = route_r[5:0];

   // time base: microsecond and millisecond ticks from clock cycles
   logic [15:0] us_cnt_r, ms_cnt_r;
   logic us_tick, ms_tick;
   assign us_tick = (us_cnt_r == 16'(US_CYCLES - 1));
   assign ms_tick = us_tick && (ms_cnt_r == 16'(US_PER_MS - 1));
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         us_cnt_r <= 16'h0000;
         ms_cnt_r <= 16'h0000;
      end
      else if (state_nxt != state_r)
      begin
         // restart with each state, else hold and soft-start times fall short by up to 1ms
         us_cnt_r <= 16'h0000;
         ms_cnt_r <= 16'h0000;
      end
      else
      begin
         us_cnt_r <= us_tick ? 16'h0000 : us_cnt_r + 16'h0001;
         if (us_tick)
            ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
      end
   end

   // enable with hysteresis between the rising and falling comparators
   logic enabled_r;
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         enabled_r <= 1'b0;
      else if (vin_lo_s || en_lo_s)
         enabled_r <= 1'b0;
      else if (vin_hi_s && en_hi_s)
         enabled_r <= 1'b1;
   end

   // sleep request filters, counted in microseconds
   logic [7:0] low_us_r, high_us_r;
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         low_us_r <= 8'h00;
         high_us_r <= 8'h00;
      end
      else
      begin
         if (sleep_n_s) low_us_r <= 8'h00;
         else if (us_tick && low_us_r != 8'hFF) low_us_r <= low_us_r + 8'h01;
         if (!sleep_n_s) high_us_r <= 8'h00;
         else if (us_tick && high_us_r != 8'hFF) high_us_r <= high_us_r + 8'h01;
      end
   end

   // per-rail sequencing, peak-limit counting and discharge
   logic [7:0] seq_ms_r, tmr_ms_r;
   logic [4:0] rail_en_r, rail_up, ss_done, ocp_r, discharge_r, stop_r;
   logic [3:0] rail_ms_r [5];
   logic [5:0] ocp_cnt_r [5];
   logic [4:0] tick_d_r, rail_en_nxt;
   logic run_state, seq_state, severe_state;

   assign run_state = (state_r == ST_POWERUP) || (state_r == ST_NORMAL) ||
                      (state_r == ST_RESET) || (state_r == ST_SLEEP) ||
                      (state_r == ST_RECOVER) || (state_r == ST_RECOVERY_RESET);
   assign seq_state = (state_r == ST_POWERUP) || (state_r == ST_RECOVER) ||
                      (state_r == ST_RECOVERY_RESET);
   assign severe_state = (state_r == ST_SAFE_SHUTDOWN) || (state_r == ST_HICCUP);

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_rail
         logic keep, start_ok;
         if (gi == 0)
         begin : g_main
            assign keep = 1'b1;
            assign start_ok = 1'b1;
         end
         else
         begin : g_sub
            assign keep = (state_r != ST_SLEEP) || sleep_rail_select_cfg[gi-1];
            assign start_ok = (state_r == ST_NORMAL) || (state_r == ST_RESET) ||
               (seq_ms_r >= 8'(`PMRS_SOFTSTART_MS) + delay_r[8*(gi-1) +: 8]);
         end
         assign rail_en_nxt[gi] = run_state && !bus_dis[gi] && keep &&
                                  (rail_en_r[gi] || start_ok);
         assign ss_done[gi] = rail_en_r[gi] && rail_ms_r[gi] >= 4'(`PMRS_SOFTSTART_MS);
         assign rail_up[gi] = bus_dis[gi] || (ss_done[gi] && !win_s[gi]);

         always_ff @(posedge CLOCK or negedge ARST_N)
         begin
            if (!ARST_N)
            begin
               rail_en_r[gi] <= 1'b0;
               rail_ms_r[gi] <= 4'h0;
               ocp_cnt_r[gi] <= 6'h00;
               ocp_r[gi] <= 1'b0;
               discharge_r[gi] <= 1'b0;
               stop_r[gi] <= 1'b0;
               tick_d_r[gi] <= 1'b0;
            end
            else
            begin
               rail_en_r[gi] <= rail_en_nxt[gi];
               if (!rail_en_nxt[gi]) rail_ms_r[gi] <= 4'h0;
               else if (ms_tick && rail_ms_r[gi] != 4'hF)
                  rail_ms_r[gi] <= rail_ms_r[gi] + 4'h1;
               tick_d_r[gi] <= tick_s[gi];
               if (!rail_en_r[gi]) ocp_cnt_r[gi] <= 6'h00;
               else if (tick_s[gi] && !tick_d_r[gi])
                  ocp_cnt_r[gi] <= peak_s[gi] ? ocp_cnt_r[gi] + 6'h01 : 6'h00;
               // latched until the restart leaves safe shutdown
               if (ocp_cnt_r[gi] == 6'(`PMRS_OCP_HITS)) ocp_r[gi] <= 1'b1;
               else if (state_r == ST_SAFE_SHUTDOWN && state_nxt != ST_SAFE_SHUTDOWN)
                  ocp_r[gi] <= 1'b0;
               stop_r[gi] <= ocp_r[gi] || ot_s || !rail_en_nxt[gi];
               discharge_r[gi] <= !rail_en_nxt[gi] && (severe_state || bus_dis[gi]);
            end
         end
      end
   endgenerate

   // events
   logic [4:0] win_evt;
   logic reset_evt, severe_evt, safe_evt, all_up, released_r, hold_done;
   assign win_evt = win_s & ss_done & fault_to_reset_routing[4:0];
   assign reset_evt = (|win_evt) ||
      (wd_fail_s && fault_to_reset_routing[`PMRS_ROUTE_WD]);
   assign severe_evt = |((sov_s & rail_en_r) | (suv_s & ss_done));
   // a latched peak-limit trip is served by the shutdown and must not block its exit
   assign safe_evt = ((|ocp_r) && state_r != ST_SAFE_SHUTDOWN) || ot_s ||
      vreg_ov_s;
   assign all_up = &rail_up;
   assign hold_done = tmr_ms_r >= reset_hold_time_cfg;

   always_comb
   begin
      state_nxt = state_r;
      if (!enabled_r)
         state_nxt = ST_OFF;
      else if (safe_evt && state_r != ST_SAFE_SHUTDOWN)
         state_nxt = ST_SAFE_SHUTDOWN;
      else if (severe_evt && run_state)
         state_nxt = ST_HICCUP;
      else
      begin
         case (state_r)
            ST_OFF:
               state_nxt = ST_POWERUP;
            ST_POWERUP:
               if (all_up) state_nxt = ST_NORMAL;
            ST_NORMAL:
               if (reset_evt) state_nxt = ST_RESET;
               else if (released_r && low_power_allow && low_us_r > blank_us)
                  state_nxt = ST_SLEEP;
            ST_RESET:
               if (hold_done && !reset_evt) state_nxt = ST_NORMAL;
            ST_SLEEP:
               if (wd_fail_s) state_nxt = ST_RECOVERY_RESET;
               else if (high_us_r > degl_us) state_nxt = ST_RECOVER;
            ST_RECOVER:
               if (reset_evt) state_nxt = ST_RECOVERY_RESET;
               else if (all_up) state_nxt = ST_NORMAL;
            ST_RECOVERY_RESET:
               if (hold_done && !reset_evt) state_nxt = ST_RECOVER;
            ST_SAFE_SHUTDOWN:
               if (!safe_evt && tmr_ms_r >= 8'(`PMRS_SAFE_TIMEOUT_MS))
                  state_nxt = ST_POWERUP;
            ST_HICCUP:
               if (tmr_ms_r >= 8'(`PMRS_HICCUP_MS)) state_nxt = ST_POWERUP;
            default:
               state_nxt = ST_OFF;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_r <= ST_OFF;
         tmr_ms_r <= 8'h00;
         seq_ms_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt != state_r) tmr_ms_r <= 8'h00;
         else if (ms_tick && tmr_ms_r != 8'hFF) tmr_ms_r <= tmr_ms_r + 8'h01;
         // recover starts the delays as if the main rail had just finished soft start
         if (state_nxt == ST_RECOVER && state_r == ST_SLEEP)
            seq_ms_r <= 8'(`PMRS_SOFTSTART_MS);
         else if (!seq_state && state_nxt == ST_POWERUP)
            seq_ms_r <= 8'h00;
         else if (ms_tick && seq_ms_r != 8'hFF)
            seq_ms_r <= seq_ms_r + 8'h01;
      end
   end

   // release after a power-up is delayed by the hold time once normal is reached
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
         released_r <= 1'b0;
      else if (!run_state || state_r == ST_POWERUP)
         released_r <= 1'b0;
      else if (state_r != ST_NORMAL || hold_done)
         released_r <= 1'b1;
   end

   logic reset_assert;
   // entry from power-up keeps the pin low until the hold time has run in normal
   assign reset_assert = (state_nxt == ST_NORMAL) ? !(released_r ||
                          (state_r != ST_NORMAL && state_r != ST_POWERUP) ||
                          (state_r == ST_NORMAL && hold_done)) :
                         !((state_nxt == ST_SLEEP) || (state_nxt == ST_RECOVER));

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         SYSTEM_RESET_OUT_O <= 1'b0;
         SYSTEM_RESET_OUT_OE_N <= 1'b0;
         WATCHDOG_RESTART <= 1'b0;
      end
      else
      begin
         SYSTEM_RESET_OUT_O <= 1'b0;
         // open drain: enable low pulls the pin low, release leaves it to the pull-up
         SYSTEM_RESET_OUT_OE_N <= !reset_assert;
         WATCHDOG_RESTART <= (state_r == ST_RESET) && (state_nxt == ST_NORMAL);
      end
   end

   // core rail clocks; b is the complement of a so they stay 180 degrees apart
   logic [7:0] sw_cnt_r;
   logic phase_a_nxt;
   assign phase_a_nxt = (sw_cnt_r == 8'(SW_HALF - 1)) ? !CORE_RAIL_A_PHASE : CORE_RAIL_A_PHASE;
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sw_cnt_r <= 8'h00;
         CORE_RAIL_A_PHASE <= 1'b0;
         CORE_RAIL_B_PHASE <= 1'b1;
      end
      else
      begin
         sw_cnt_r <= (sw_cnt_r == 8'(SW_HALF - 1)) ? 8'h00 : sw_cnt_r + 8'h01;
         CORE_RAIL_A_PHASE <= phase_a_nxt;
         CORE_RAIL_B_PHASE <= !phase_a_nxt;
      end
   end

   assign status = {11'h000, released_r, enabled_r, ocp_r, rail_up, rail_en_r, 4'(state_r)};
   assign RAIL_ENABLE = rail_en_r;
   assign RAIL_DISCHARGE = discharge_r;
   assign RAIL_SWITCH_STOP = stop_r;
   assign CORE_RAIL_A_VSET = vset_r[4:0];
   assign CORE_RAIL_B_VSET = vset_r[12:8];
   assign SEVERE_OVER_LIMIT_SEL = ctrl_r[`PMRS_CTRL_OVSEL_LSB +: 2];
   assign SEVERE_UNDER_LIMIT_SEL = ctrl_r[`PMRS_CTRL_UVSEL_LSB +: 2];
   assign RAIL_WINDOW_CFG_A = window_r[7:0];
   assign RAIL_WINDOW_CFG_B = window_r[15:8];

endmodule
`default_nettype wire

// ### test/pmrs_assertions.sv
// port checker for the reset/sleep controller, bound into the top
// assumes fault inputs are held over two clocks; sync plus state plus output is 4 edges
`timescale 1ns/10ps
`default_nettype none
module pmrs_assertions (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic [4:0] RAIL_SEVERE_OV,
   input wire logic [4:0] RAIL_SEVERE_UV,
   input wire logic WATCHDOG_FAIL,
   input wire logic OVER_TEMP,
   input wire logic SYSTEM_RESET_OUT_OE_N,
   input wire logic [4:0] RAIL_ENABLE,
   input wire logic [4:0] RAIL_DISCHARGE,
   input wire logic [4:0] RAIL_SWITCH_STOP,
   input wire logic WATCHDOG_RESTART,
   input wire logic CORE_RAIL_A_PHASE,
   input wire logic CORE_RAIL_B_PHASE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   chk_phase_anti: assert property (CORE_RAIL_B_PHASE == !CORE_RAIL_A_PHASE)
      else $error("phases not opposite");
   chk_main_first: assert property (!RAIL_ENABLE[0] |-> RAIL_ENABLE[4:1] == 4'h0)
      else $error("rail on before main");
   chk_wd_pulse: assert property (WATCHDOG_RESTART |->
      RAIL_ENABLE == 5'h1F ##1 !WATCHDOG_RESTART) else $error("restart pulse wrong");
   chk_discharge_off: assert property ((RAIL_DISCHARGE & RAIL_ENABLE) == 5'h00)
      else $error("discharge on live rail");
   chk_severe_ov: assert property ($rose(|RAIL_SEVERE_OV) && RAIL_ENABLE[0] |->
      ##[1:6] RAIL_ENABLE == 5'h00 && RAIL_DISCHARGE == 5'h1F) else $error("no ov hiccup");
   chk_severe_uv: assert property ($rose(|RAIL_SEVERE_UV) && RAIL_ENABLE[0] |->
      ##[1:6] RAIL_ENABLE == 5'h00 && RAIL_DISCHARGE == 5'h1F) else $error("no uv hiccup");
   chk_thermal_stop: assert property ($rose(OVER_TEMP) |->
      ##[1:6] RAIL_SWITCH_STOP == 5'h1F && !SYSTEM_RESET_OUT_OE_N) else $error("no stop");
   chk_wd_reset: assert property ($rose(WATCHDOG_FAIL) && SYSTEM_RESET_OUT_OE_N
      && RAIL_ENABLE == 5'h1F |-> ##[1:6] !SYSTEM_RESET_OUT_OE_N) else $error("no reset");
endmodule
bind pmrs_top pmrs_assertions i_pmrs_assertions (.CLOCK, .ARST_N, .RAIL_SEVERE_OV,
   .RAIL_SEVERE_UV, .WATCHDOG_FAIL, .OVER_TEMP, .SYSTEM_RESET_OUT_OE_N, .RAIL_ENABLE,
   .RAIL_DISCHARGE, .RAIL_SWITCH_STOP, .WATCHDOG_RESTART, .CORE_RAIL_A_PHASE, .CORE_RAIL_B_PHASE);
`default_nettype wire

// ### test/pmrs_mcu_model.sv
// mcu stand-in: drives the sleep pin, sees the resolved reset line
// assumes the bench resolves the open-drain reset with its pull-up
`timescale 1ns/10ps
`default_nettype none
module pmrs_mcu_model (
   input wire logic CLOCK,
   input wire logic reset_line,
   input wire logic want_sleep,
   output var logic sleep_request_n
);
   // an mcu held in reset cannot keep the pin low
   always @(posedge CLOCK)
   begin
      sleep_request_n <= !(want_sleep && reset_line === 1'h1);
   end
endmodule
`default_nettype wire

// ### test/pmrs_top_tb_top.sv
// bench for the reset/sleep controller: apb tasks, mcu model, fault stimulus
// assumes the bound checker; timing shortened to 8 clocks a millisecond
`timescale 1ns/10ps
`default_nettype none
module pmrs_top_tb_top;
   localparam int MS = 8;
   logic CLOCK = 1'h0, ARST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic PREADY, PSLVERR, ro, roe, wdr, pa, pb, sleep_n;
   logic wdf = 1'h0, ot = 1'h0, vr = 1'h0, er = 1'h0, rov = 1'h0, want = 1'h0;
   logic [7:0] PADDR = 8'h00, wa, wb;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic [4:0] wf = 5'h00, sov = 5'h00, suv = 5'h00, pk = 5'h00, tk = 5'h00;
   logic [4:0] en, dis, stop, va, vb;
   logic [1:0] osel, usel;
   int err_count = 0, checks = 0, cyc = 0, restarts = 0;
   wire logic rst_line = roe ? 1'h1 : ro;
   pmrs_top #(.US_CYCLES(2), .US_PER_MS(4)) i_pmrs_top (.CLOCK, .ARST_N, .PSEL, .PENABLE,
      .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RAIL_WINDOW_FAULT(wf),
      .RAIL_SEVERE_OV(sov), .RAIL_SEVERE_UV(suv), .RAIL_PEAK_LIMIT(pk), .RAIL_CYCLE_TICK(tk),
      .WATCHDOG_FAIL(wdf), .OVER_TEMP(ot), .VIN_ABOVE_RISE(vr), .VIN_BELOW_FALL(!vr),
      .EN_ABOVE_ON(er), .EN_BELOW_OFF(!er), .REG_SUPPLY_OV(rov), .SLEEP_REQUEST_N(sleep_n),
      .SYSTEM_RESET_OUT_O(ro), .SYSTEM_RESET_OUT_OE_N(roe), .RAIL_ENABLE(en),
      .RAIL_DISCHARGE(dis), .RAIL_SWITCH_STOP(stop), .WATCHDOG_RESTART(wdr),
      .CORE_RAIL_A_VSET(va), .CORE_RAIL_B_VSET(vb), .CORE_RAIL_A_PHASE(pa),
      .CORE_RAIL_B_PHASE(pb), .SEVERE_OVER_LIMIT_SEL(osel), .SEVERE_UNDER_LIMIT_SEL(usel),
      .RAIL_WINDOW_CFG_A(wa), .RAIL_WINDOW_CFG_B(wb));
   pmrs_mcu_model i_pmrs_mcu_model (.CLOCK, .reset_line(rst_line), .want_sleep(want),
      .sleep_request_n(sleep_n));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
      @(posedge CLOCK);
      PSEL <= 1'h1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'h1;
      @(posedge CLOCK iff PREADY === 1'h1);
      check(PSLVERR, e, "slave error");
      if (!wr)
         check(PRDATA, d, "read data");
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask
   always #5 CLOCK = !CLOCK;
   // one ceiling covers every wait below
   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      restarts <= restarts + int'(wdr === 1'h1);
      if (cyc == 20000)
      begin
         err_count++;
         $display("MISMATCH at %0t: timeout", $time);
         final_report();
      end
   end
   initial
   begin
      repeat (4) @(posedge CLOCK);
      ARST_N <= 1'h1;
      apb(1'h0, 8'h04, 32'h0000_000A, 1'h0);
      apb(1'h0, 8'h08, 32'h0014_1400, 1'h0);
      apb(1'h0, 8'h0C, 32'h0000_003F, 1'h0);
      apb(1'h0, 8'h18, 32'h0000_0808, 1'h0);
      apb(1'h0, 8'h20, 32'h0, 1'h1);
      apb(1'h1, 8'h1C, 32'h0, 1'h1);
      apb(1'h1, 8'h04, 32'h0000_0002, 1'h0);
      apb(1'h1, 8'h10, 32'h4B02_0100, 1'h0);
      apb(1'h1, 8'h18, 32'h0000_1F00, 1'h0);
      apb(1'h1, 8'h14, 32'h0000_A55A, 1'h0);
      apb(1'h1, 8'h00, 32'h0000_0900, 1'h0);
      apb(1'h1, 8'h08, 32'h0002_0201, 1'h0);
      @(posedge CLOCK);
      check({osel, usel, va, vb, wa, wb}, {14'h181F, 16'h5AA5}, "cfg");
      vr <= 1'h1;
      repeat (20) @(posedge CLOCK);
      check(en, 5'h00, "half enable");
      er <= 1'h1;
      @(posedge CLOCK iff en[0] === 1'h1);
      check(en, 5'h01, "main first");
      repeat (MS - 2) @(posedge CLOCK);
      check(en, 5'h01, "soft start");
      @(posedge CLOCK iff en === 5'h1F);
      @(posedge CLOCK iff roe === 1'h1);
      $display("power-up done");
      for (int k = 0; k < 2; k++)
      begin
         if (k == 0)
            wf <= 5'h04;
         else
            wdf <= 1'h1;
         repeat (4) @(posedge CLOCK);
         wf <= 5'h00;
         wdf <= 1'h0;
         @(posedge CLOCK iff roe === 1'h0);
         check(en, 5'h1F, "rails in reset");
         repeat (2 * MS - 4) @(posedge CLOCK);
         check(roe, 1'h0, "hold");
         @(posedge CLOCK iff roe === 1'h1);
         repeat (3) @(posedge CLOCK);
         check(restarts, k + 1, "wd restart");
      end
      $display("reset events done");
      want <= 1'h1;
      repeat (40) @(posedge CLOCK);
      check(en, 5'h1F, "sleep refused");
      want <= 1'h0;
      apb(1'h1, 8'h00, 32'h0000_0901, 1'h0);
      want <= 1'h1;
      @(posedge CLOCK iff en === 5'h03);
      check(roe, 1'h1, "reset in sleep");
      want <= 1'h0;
      repeat (12) @(posedge CLOCK);
      wf <= 5'h02;
      repeat (4) @(posedge CLOCK);
      wf <= 5'h00;
      @(posedge CLOCK iff roe === 1'h0);
      check(en[1:0], 2'h3, "recovery reset");
      @(posedge CLOCK iff roe === 1'h1);
      @(posedge CLOCK iff en === 5'h1F);
      apb(1'h0, 8'h00, 32'h0000_0900, 1'h0);
      $display("sleep done");
      for (int k = 0; k < 5; k++)
      begin
         sov <= {4'h0, k == 0};
         suv <= {4'h0, k == 1};
         ot <= k == 2;
         rov <= k == 3;
         pk <= {3'h0, k == 4, 1'h0};
         // 32 tick edges at four clocks each, with margin for the synchroniser
         repeat (160 * (k == 4)) @(posedge CLOCK) tk <= tk ^ {3'h0, cyc[1] ^ tk[1], 1'h0};
         @(posedge CLOCK iff en === 5'h00);
         check({ro, roe, stop}, {2'h0, 5'h1F}, "stopped");
         if (k < 2)
            check(dis, 5'h1F, "discharge");
         {sov, suv, ot, rov, pk} <= '0;
         @(posedge CLOCK iff roe === 1'h1);
         check(en, 5'h1F, "restart");
      end
      $display("protection done");
      final_report();
   end
endmodule
`default_nettype wire
